// ---- verilog/thcr_consts.vh ----
// constants for the terminal host control register bank
//
// Behaviour
// - interrupt mask: bit 15 reserved, bits 14..0 enable one source each
// - pending status at 18h, same source order, bit 15 master indication
// - config one bits 15,14: 00 controller, 10 terminal, 01 monitor
// - config one bit 13 selects current memory area A or B
// - controller bits 12..3 control options, effective only when enhanced
// - controller bits 2..0 read-only enabled/frame/message status
// - terminal alternate status, enhanced only: bits 12..1 give status bits
// - terminal bit 0 read-only message in progress, enhanced if no alt
// - monitor bits 12,11,10,9,7 controls; 2..0 read-only; enhanced only
// - config two bits 9..7 select time tag resolution
// - config two bits 6,5 clear or load time tag on synchronize
// - config two bit 4 auto clear, bit 3 level/pulse, bit 15 enhanced irq
// - config two option enables at bits 14,13,11,10,2,1,0
// - write at 0Ch gives command strobes on bits 0..6, 9..11
// - read at 0Ch returns the command stack pointer
`ifndef THCR_CONSTS_VH
`define THCR_CONSTS_VH
`define THCR_OFS_MASK 7'h00
`define THCR_OFS_CFG1 7'h04
`define THCR_OFS_CFG2 7'h08
`define THCR_OFS_STRB 7'h0C
`define THCR_OFS_ISTS 7'h18
`define THCR_RST_VAL 16'h0000
`define THCR_MASK_WMSK 16'h7FFF
`define THCR_CFG2_WMSK 16'hEFFF
`define THCR_STRB_WMSK 16'h0E7F
`define THCR_ROLE_BC 2'h0
`define THCR_ROLE_RT 2'h2
`define THCR_ROLE_MT 2'h1
`define THCR_B_ROLE_HI 15
`define THCR_B_ROLE_LO 14
`define THCR_B_AREA 13
`define THCR_B_MSTR 15
`define THCR_BC_OPT_WMSK 16'h1FF8
`define THCR_RT_WMSK 16'h1F80
`define THCR_RT_ENH_WMSK 16'h0080
`define THCR_RT_ALT_WMSK 16'h1FFE
`define THCR_MT_WMSK 16'h1E80
`define THCR_B_TTR_HI 9
`define THCR_B_TTR_LO 7
`define THCR_B_SYNC_CLR 6
`define THCR_B_SYNC_LD 5
`define THCR_B_AUTOCLR 4
`define THCR_B_PULSE 3
`define THCR_B_ENH_IRQ 15
`define THCR_B_PAR_EN 14
`define THCR_B_BUSY_LUT 13
`define THCR_B_OVWR 11
`define THCR_B_BND_DIS 10
`define THCR_B_CLR_SRQ 2
`define THCR_B_ENH_MM 1
`define THCR_B_SEP_BC 0
`define THCR_B_RO_EN 2
`define THCR_B_RO_FRM 1
`define THCR_B_RO_MSG 0
`define THCR_B_MODE_HI 12
`define THCR_MODE_WMSK 16'h1FFF
`define THCR_FE_PAR 6
`define THCR_FE_BUSY 5
`define THCR_FE_OVWR 4
`define THCR_FE_BND 3
`define THCR_FE_SRQ 2
`define THCR_FE_MM 1
`define THCR_FE_SEP 0
`endif

// ---- verilog/thcr_strobe.v ----
// one-cycle strobe generator for the command strobe word
`timescale 1ns/1ps
module thcr_strobe #(
  parameter WIDTH = 16
) (
  input wire mclk_i,
  input wire rst_i,
  input wire wr_i,
  input wire [WIDTH-1:0] data_i,
  input wire [WIDTH-1:0] keep_i,
  output reg [WIDTH-1:0] pulse_o
);
  // reserved lanes are masked, value never kept past one cycle
  always @(posedge mclk_i) begin
    if (rst_i) begin
      pulse_o <= {WIDTH{1'b0}};
    end else if (wr_i) begin
      pulse_o <= data_i & keep_i;
    end else begin
      pulse_o <= {WIDTH{1'b0}};
    end
  end
endmodule

// ---- verilog/thcr_regs.v ----
// host control and configuration register bank of the bus terminal
`timescale 1ns/1ps
`include "thcr_consts.vh"
module thcr_regs #(
  parameter AW = 7,
  parameter DW = 16
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [AW-1:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [DW-1:0] wdata_i,
  input wire enhanced_i,
  input wire alt_status_i,
  input wire bc_enabled_i,
  input wire bc_frame_busy_i,
  input wire msg_busy_i,
  input wire mt_enabled_i,
  input wire mt_triggered_i,
  input wire mt_active_i,
  input wire [DW-2:0] irq_pending_i,
  input wire irq_master_i,
  input wire [DW-1:0] cmd_stack_ptr_i,
  output reg [DW-1:0] rdata_o,
  output reg rvalid_o,
  output reg [DW-1:0] irq_mask_o,
  output reg [1:0] role_o,
  output reg area_b_o,
  output reg [12:0] mode_bits_o,
  output reg [2:0] time_tag_res_o,
  output reg sync_clear_tt_o,
  output reg sync_load_tt_o,
  output reg irq_auto_clear_o,
  output reg irq_pulse_mode_o,
  output reg enh_irq_o,
  output reg [6:0] feature_en_o,
  output wire [DW-1:0] strobe_o
);
  // ***************************************
  // register storage
  // ***************************************
  reg [DW-1:0] mask_q;
  reg [DW-1:0] cfg1_q;
  reg [DW-1:0] cfg2_q;
  // next-state and read views
  reg [DW-1:0] cfg1_d;
  reg [DW-1:0] rd_d;
  wire wr_mask;
  wire wr_cfg1;
  wire wr_cfg2;
  wire wr_strb;
  wire [1:0] new_role;

  // offset compare shared by every write decode
  function hit;
    input [AW-1:0] a;
    input [AW-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // one write enable per writable offset
  assign wr_mask = wr_i & hit(addr_i, `THCR_OFS_MASK);
  assign wr_cfg1 = wr_i & hit(addr_i, `THCR_OFS_CFG1);
  assign wr_cfg2 = wr_i & hit(addr_i, `THCR_OFS_CFG2);
  assign wr_strb = wr_i & hit(addr_i, `THCR_OFS_STRB);
  // role being written decides which lanes the write may set
  assign new_role = wdata_i[`THCR_B_ROLE_HI:`THCR_B_ROLE_LO];

  // ***************************************
  // configuration one write merge
  // ***************************************
  // writable field depends on role written; read-only status bits never stored
  always @* begin
    cfg1_d = cfg1_q;
    if (wr_cfg1) begin
      cfg1_d = `THCR_RST_VAL;
      cfg1_d[`THCR_B_ROLE_HI] = wdata_i[`THCR_B_ROLE_HI];
      cfg1_d[`THCR_B_ROLE_LO] = wdata_i[`THCR_B_ROLE_LO];
      cfg1_d[`THCR_B_AREA] = wdata_i[`THCR_B_AREA];
      case (new_role)
        `THCR_ROLE_BC: begin
          // controller options only, status lanes stay zero
          cfg1_d = cfg1_d | (wdata_i & `THCR_BC_OPT_WMSK);
        end
        `THCR_ROLE_RT: begin
          // alternate status lanes need enhanced operation
          if (enhanced_i && alt_status_i) begin
            cfg1_d = cfg1_d | (wdata_i & `THCR_RT_ALT_WMSK);
          end else begin
            cfg1_d = cfg1_d | (wdata_i & `THCR_RT_WMSK);
          end
        end
        `THCR_ROLE_MT: begin
          // monitor controls only, status lanes stay zero
          cfg1_d = cfg1_d | (wdata_i & `THCR_MT_WMSK);
        end
        default: begin
          cfg1_d = cfg1_d;
        end
      endcase
    end
  end

  // interrupt mask storage
  always @(posedge mclk_i) begin
    if (rst_i) begin
      mask_q <= `THCR_RST_VAL;
    end else if (wr_mask) begin
      mask_q <= wdata_i & `THCR_MASK_WMSK;
    end
  end

  // configuration one storage, merged above
  always @(posedge mclk_i) begin
    if (rst_i) begin
      cfg1_q <= `THCR_RST_VAL;
    end else begin
      cfg1_q <= cfg1_d;
    end
  end

  // configuration two storage
  always @(posedge mclk_i) begin
    if (rst_i) begin
      cfg2_q <= `THCR_RST_VAL;
    end else if (wr_cfg2) begin
      // bit 12 held at zero whatever the host sends
      cfg2_q <= wdata_i & `THCR_CFG2_WMSK;
    end
  end

  // ***************************************
  // read mux
  // ***************************************
  always @* begin
    rd_d = cfg1_q;
    case (cfg1_q[`THCR_B_ROLE_HI:`THCR_B_ROLE_LO])
      `THCR_ROLE_BC: begin
        // live controller status over the stored lanes
        rd_d[`THCR_B_RO_EN] = bc_enabled_i;
        rd_d[`THCR_B_RO_FRM] = bc_frame_busy_i;
        rd_d[`THCR_B_RO_MSG] = msg_busy_i;
      end
      `THCR_ROLE_RT: begin
        // message in progress bit reads as zero outside enhanced operation
        rd_d[`THCR_B_RO_MSG] = msg_busy_i & enhanced_i;
      end
      `THCR_ROLE_MT: begin
        // live monitor status over the stored lanes
        rd_d[`THCR_B_RO_EN] = mt_enabled_i;
        rd_d[`THCR_B_RO_FRM] = mt_triggered_i;
        rd_d[`THCR_B_RO_MSG] = mt_active_i;
      end
      default: begin
        rd_d = cfg1_q;
      end
    endcase
  end

  // read valid follows the read strobe by one cycle
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
    end
  end

  // read data holds until the next read
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= `THCR_RST_VAL;
    end else if (rd_i) begin
      case (addr_i)
        `THCR_OFS_MASK: rdata_o <= mask_q;
        `THCR_OFS_CFG1: rdata_o <= rd_d;
        `THCR_OFS_CFG2: rdata_o <= cfg2_q;
        `THCR_OFS_STRB: rdata_o <= cmd_stack_ptr_i;
        `THCR_OFS_ISTS: begin
          rdata_o <= {irq_master_i, irq_pending_i};
        end
        // unmapped offsets read as zero
        default: rdata_o <= `THCR_RST_VAL;
      endcase
    end
  end

  // ***************************************
  // decoded control outputs
  // ***************************************
  // mode field as the protocol engines see it
  function [DW-1:0] eff_mode;
    input [DW-1:0] c;
    input enh;
    begin
      if (c[`THCR_B_ROLE_HI:`THCR_B_ROLE_LO] == `THCR_ROLE_RT) begin
        if (enh) begin
          eff_mode = c & `THCR_MODE_WMSK;
        end else begin
          // terminal flag needs enhanced operation
          eff_mode = c & `THCR_MODE_WMSK & ~`THCR_RT_ENH_WMSK;
        end
      end else if (enh) begin
        eff_mode = c & `THCR_MODE_WMSK;
      end else begin
        // controller and monitor options idle outside enhanced
        eff_mode = `THCR_RST_VAL;
      end
    end
  endfunction

  wire [DW-1:0] mode_d;
  assign mode_d = eff_mode(cfg1_q, enhanced_i);

  // interrupt mask mirror
  always @(posedge mclk_i) begin
    if (rst_i) begin
      irq_mask_o <= `THCR_RST_VAL;
    end else begin
      irq_mask_o <= mask_q;
    end
  end

  // role and working area
  always @(posedge mclk_i) begin
    if (rst_i) begin
      role_o <= `THCR_ROLE_BC;
      area_b_o <= 1'b0;
    end else begin
      role_o <= cfg1_q[`THCR_B_ROLE_HI:`THCR_B_ROLE_LO];
      area_b_o <= cfg1_q[`THCR_B_AREA];
    end
  end

  // effective mode bits
  always @(posedge mclk_i) begin
    if (rst_i) begin
      mode_bits_o <= 13'h0000;
    end else begin
      mode_bits_o <= mode_d[`THCR_B_MODE_HI:0];
    end
  end

  // time tag controls
  // sync actions apply at the next synchronize command
  always @(posedge mclk_i) begin
    if (rst_i) begin
      time_tag_res_o <= 3'h0;
      sync_clear_tt_o <= 1'b0;
      sync_load_tt_o <= 1'b0;
    end else begin
      time_tag_res_o <= cfg2_q[`THCR_B_TTR_HI:`THCR_B_TTR_LO];
      sync_clear_tt_o <= cfg2_q[`THCR_B_SYNC_CLR];
      sync_load_tt_o <= cfg2_q[`THCR_B_SYNC_LD];
    end
  end

  // interrupt signalling options
  always @(posedge mclk_i) begin
    if (rst_i) begin
      irq_auto_clear_o <= 1'b0;
      irq_pulse_mode_o <= 1'b0;
      enh_irq_o <= 1'b0;
    end else begin
      irq_auto_clear_o <= cfg2_q[`THCR_B_AUTOCLR];
      irq_pulse_mode_o <= cfg2_q[`THCR_B_PULSE];
      enh_irq_o <= cfg2_q[`THCR_B_ENH_IRQ];
    end
  end

  // memory and buffering feature enables
  always @(posedge mclk_i) begin
    if (rst_i) begin
      feature_en_o <= 7'h00;
    end else begin
      feature_en_o[`THCR_FE_PAR] <= cfg2_q[`THCR_B_PAR_EN];
      feature_en_o[`THCR_FE_BUSY] <= cfg2_q[`THCR_B_BUSY_LUT];
      feature_en_o[`THCR_FE_OVWR] <= cfg2_q[`THCR_B_OVWR];
      feature_en_o[`THCR_FE_BND] <= cfg2_q[`THCR_B_BND_DIS];
      feature_en_o[`THCR_FE_SRQ] <= cfg2_q[`THCR_B_CLR_SRQ];
      feature_en_o[`THCR_FE_MM] <= cfg2_q[`THCR_B_ENH_MM];
      feature_en_o[`THCR_FE_SEP] <= cfg2_q[`THCR_B_SEP_BC];
    end
  end

  // ***************************************
  // command strobes
  // ***************************************
  // reserved lanes dropped, each pulse lasts one cycle
  thcr_strobe #(
    .WIDTH(DW)
  ) u_strobe (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_i(wr_strb),
    .data_i(wdata_i),
    .keep_i(`THCR_STRB_WMSK),
    .pulse_o(strobe_o)
  );
endmodule

// ---- verification/thcr_host.sv ----
// host model issuing register bank accesses
`timescale 1ns/1ps
module thcr_host (
  input wire mclk_i,
  input wire [15:0] rdata_i,
  output reg [6:0] addr_o = 7'h00,
  output reg wr_o = 1'b0,
  output reg rd_o = 1'b0,
  output reg [15:0] wdata_o = 16'h0000
);
  task wr(input [6:0] a, input [15:0] d);
    begin
      @(negedge mclk_i);
      addr_o = a;
      wdata_o = (a == 7'h08) ? (d & 16'hEFFF) : d;
      wr_o = 1'b1;
      @(negedge mclk_i);
      wr_o = 1'b0;
      wdata_o = ~wdata_o;
    end
  endtask
  task rd(input [6:0] a, output [15:0] d);
    begin
      @(negedge mclk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge mclk_i);
      rd_o = 1'b0;
      d = rdata_i;
    end
  endtask
endmodule

// ---- verification/thcr_regs_sva.sv ----
// port assertions for the register bank
`timescale 1ns/1ps
module thcr_regs_sva (
  input wire mclk_i,
  input wire rst_i,
  input wire [6:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] wdata_i,
  input wire [14:0] irq_pending_i,
  input wire irq_master_i,
  input wire [15:0] cmd_stack_ptr_i,
  input wire [15:0] rdata_o,
  input wire rvalid_o,
  input wire [1:0] role_o,
  input wire area_b_o,
  input wire [2:0] time_tag_res_o,
  input wire [15:0] strobe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire ws = wr_i && addr_i == 7'h0C;
  wire w1 = wr_i && addr_i == 7'h04;
  wire w2 = wr_i && addr_i == 7'h08;
  wire rc = rd_i && addr_i == 7'h0C;
  wire ri = rd_i && addr_i == 7'h18;
  rd_valid_a: assert property (rvalid_o == $past(rd_i))
    else $error("read valid out of step");
  csp_read_a: assert property (
    rc |=> rdata_o == $past(cmd_stack_ptr_i))
    else $error("stack pointer read wrong");
  strobe_pulse_a: assert property (
    ws |=> strobe_o == ($past(wdata_i) & 16'h0E7F))
    else $error("strobe word wrong");
  strobe_clear_a: assert property (!ws |=> strobe_o == 16'h0000)
    else $error("strobe kept");
  status_read_a: assert property (
    ri |=> rdata_o == {$past(irq_master_i), $past(irq_pending_i)})
    else $error("status read wrong");
  role_dec_a: assert property (
    w1 |=> ##1 role_o == $past(wdata_i[15:14], 2))
    else $error("role wrong");
  area_sel_a: assert property (
    w1 |=> ##1 area_b_o == $past(wdata_i[13], 2))
    else $error("area wrong");
  tt_res_a: assert property (
    w2 |=> ##1 time_tag_res_o == $past(wdata_i[9:7], 2))
    else $error("time tag resolution wrong");
  cover property (ws);
  cover property (w1 && wdata_i[15:14] == 2'h1);
  cover property (rd_i && addr_i == 7'h0C);
endmodule
bind thcr_regs thcr_regs_sva chk_u (.mclk_i(mclk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
  .irq_pending_i(irq_pending_i), .irq_master_i(irq_master_i),
  .cmd_stack_ptr_i(cmd_stack_ptr_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .role_o(role_o), .area_b_o(area_b_o),
  .time_tag_res_o(time_tag_res_o), .strobe_o(strobe_o));

// ---- verification/tb_top.sv ----
// self-checking bench for the register bank
`timescale 1ns/1ps
module tb_top;
  reg mclk_i = 1'b0;
  reg rst_i = 1'b1;
  reg enh = 1'b1;
  reg alt = 1'b0;
  reg mstr = 1'b0;
  reg [5:0] st = 6'h00;
  reg [14:0] pend = 15'h0000;
  reg [15:0] csp = 16'h0000;
  reg [31:0] rs = 32'd9206;
  reg [15:0] d, g;
  integer err_total = 0, n_checks = 0, i, k;
  wire [6:0] addr, feat;
  wire wr, rd, enh_irq, rvld, areab, sclr, sld, aclr, pls;
  wire [15:0] wdata, rdata, mask, strb;
  wire [2:0] ttr;
  wire [1:0] role;
  wire [12:0] mbits;
  always #12.5 mclk_i = ~mclk_i;
  thcr_host host_u (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  thcr_regs dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr),
    .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .enhanced_i(enh),
    .alt_status_i(alt), .bc_enabled_i(st[2]), .bc_frame_busy_i(st[1]),
    .msg_busy_i(st[0]), .mt_enabled_i(st[5]), .mt_triggered_i(st[4]),
    .mt_active_i(st[3]), .irq_pending_i(pend), .irq_master_i(mstr),
    .cmd_stack_ptr_i(csp), .rdata_o(rdata), .rvalid_o(rvld),
    .irq_mask_o(mask), .role_o(role), .area_b_o(areab),
    .mode_bits_o(mbits), .time_tag_res_o(ttr),
    .sync_clear_tt_o(sclr), .sync_load_tt_o(sld),
    .irq_auto_clear_o(aclr), .irq_pulse_mode_o(pls), .enh_irq_o(enh_irq),
    .feature_en_o(feat), .strobe_o(strb));
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // expected config one readback per role
  function [15:0] c1x(input [15:0] v);
    begin
      if (v[15:14] == 2'h0)
        c1x = (v & 16'hFFF8) | {13'h0, st[2:0]};
      else if (v[15:14] == 2'h1)
        c1x = (v & 16'hFE80) | {13'h0, st[5:3]};
      else if (v[15:14] == 2'h3)
        c1x = v & 16'hE000;
      else if (alt && enh)
        c1x = (v & 16'hFFFE) | {15'h0, st[0]};
      else
        c1x = (v & 16'hFF80) | {15'h0, st[0] & enh};
    end
  endfunction
  // expected effective mode bits per role
  function [15:0] mbx(input [15:0] v);
    reg [15:0] s;
    begin
      if (v[15:14] == 2'h0)
        s = v & 16'h1FF8;
      else if (v[15:14] == 2'h1)
        s = v & 16'h1E80;
      else if (v[15:14] == 2'h3)
        s = 16'h0000;
      else
        s = v & ((alt && enh) ? 16'h1FFE : 16'h1F80);
      if (v[15:14] == 2'h2)
        mbx = enh ? s : (s & 16'h1F7F);
      else
        mbx = enh ? s : 16'h0000;
    end
  endfunction
  task chk(input [8*6-1:0] nm, input [15:0] ex, input [15:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== ex) begin
        err_total = err_total + 1;
        $display("MISMATCH %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #(25 * 4000);
    err_total = err_total + 1;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    for (i = 0; i < 40; i = i + 1) begin
      rs = xs(rs);
      d = (i < 5) ? 16'hFFFF : rs[15:0];
      {st, pend, mstr} = rs[31:10];
      csp = rs[15:0] ^ rs[31:16];
      k = i % 5;
      if (k == 0) begin
        host_u.wr(7'h00, d);
        host_u.rd(7'h00, g);
        chk("mask", d & 16'h7FFF, g);
        chk("masko", d & 16'h7FFF, mask);
      end else if (k == 1) begin
        host_u.wr(7'h08, d);
        host_u.rd(7'h08, g);
        chk("cfg2", d & 16'hEFFF, g);
        chk("ttr", {13'h0, d[9:7]}, {13'h0, ttr});
        chk("sync", d[6:3], {sclr, sld, aclr, pls});
        chk("feat", {d[14:13], d[11:10], d[2:0]}, feat);
        chk("eirq", {15'h0, d[15]}, {15'h0, enh_irq});
      end else if (k == 2) begin
        d[15:14] = (i % 4 == 0) ? 2'h0 : (i % 4 == 1) ? 2'h2 :
                   (i % 4 == 2) ? 2'h1 : 2'h3;
        enh = rs[20];
        alt = rs[21];
        host_u.wr(7'h04, d);
        host_u.rd(7'h04, g);
        chk("cfg1", c1x(d), g);
        chk("mbits", mbx(d), {3'h0, mbits});
        chk("role", d[15:14], role);
        chk("area", d[13], areab);
      end else if (k == 3) begin
        host_u.wr(7'h0C, d);
        chk("strb", d & 16'h0E7F, strb);
        @(negedge mclk_i);
        chk("strb0", 16'h0000, strb);
        host_u.rd(7'h0C, g);
        chk("csp", csp, g);
      end else begin
        host_u.rd(7'h18, g);
        chk("ists", {mstr, pend}, g);
        chk("rvld", 16'h0001, {15'h0, rvld});
        host_u.rd(7'h10, g);
        chk("unmap", 16'h0000, g);
      end
      $display("test %0d kind %0d done", i, k);
    end
    print_verdict;
  end
endmodule
